// ---- bench/framer_model.sv ----
// framer model that offers sign/magnitude pairs on the channel unit transmit interface
`timescale 1ns/10ps
module framer_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // bench control
    input wire logic active,
    input wire logic slow,
    // channel unit transmit interface
    input wire logic cu_ready,
    output logic cu_valid,
    output logic cu_sign,
    output logic cu_mag
);
    integer seed = 32'hA6BA;
    logic taken;

    initial begin
        cu_valid = 1'b0;
        {cu_sign, cu_mag} = 2'h0;
        taken = 1'b0;
    end

    always @(posedge clk_sys) begin
        taken <= cu_valid & cu_ready;
    end

    // a pair stays put until an edge takes it; idle lines carry noise, not the last pair
    always @(negedge clk_sys) begin
        if (rst) begin
            cu_valid <= 1'b0;
        end else if (!cu_valid || taken) begin
            cu_valid <= active && (!slow || ($random(seed) & 3) == 0);
            {cu_sign, cu_mag} <= 2'($random(seed));
        end
    end
endmodule

// ---- bench/test_tx_symbol_source.sv ----
// self-checking bench of the transmit symbol source and timer bank
`timescale 1ns/10ps
module test_tx_symbol_source;
    localparam int MET_INT = 5;
    logic clk_sys, rst, reg_wr, reg_rd, det_sign, det_mag;
    logic cu_valid, cu_sign, cu_mag, cu_ready, active, slow;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, tcont;
    logic [7:0][15:0] tint, timer_count;
    logic [15:0] held;
    logic [1:0] pair;
    logic [1:0] sent [$];
    logic [39:0] sig [2];
    tx_pkg::level_t dac_level;
    tx_pkg::level_t s [60];
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int data_mode = 0;
    integer seed = 32'hA6BA;

    tx_symbol_source tx_symbol_source_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cu_valid(cu_valid), .cu_sign(cu_sign), .cu_mag(cu_mag), .cu_ready(cu_ready),
        .det_sign(det_sign), .det_mag(det_mag), .timer_interval(tint),
        .timer_continuous(tcont), .dac_level(dac_level), .timer_count(timer_count));

    framer_model framer_model_i (.clk_sys(clk_sys), .rst(rst), .active(active), .slow(slow),
        .cu_ready(cu_ready), .cu_valid(cu_valid), .cu_sign(cu_sign), .cu_mag(cu_mag));

    task complete_run;
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task note(input string n, input bit bad, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (bad) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task cmp_reg(input string n, input logic [7:0] e, input logic [7:0] g);
        note(n, g !== e, 16'(e), 16'(g));
    endtask

    task cmp_count(input string n, input logic [15:0] e, input logic [15:0] g);
        note(n, g !== e, e, g);
    endtask

    task cmp_level(input string n, input tx_pkg::level_t e, input tx_pkg::level_t g);
        note(n, g !== e, 16'(e), 16'(g));
    endtask

    task cmp_flag(input string n, input logic e, input logic g);
        note(n, g !== e, 16'(e), 16'(g));
    endtask

    // the pulse level code and a sign/magnitude pair share one encoding
    function automatic tx_pkg::level_t exp_level(input logic [1:0] c);
        case (c)
            2'h0: return 3'h5;
            2'h1: return 3'h7;
            2'h2: return 3'h3;
            default: return 3'h1;
        endcase
    endfunction

    function automatic bit legal(input tx_pkg::level_t v, input int m);
        if (m == 7) return v === 3'h3 || v === 3'h5;
        return v === 3'h1 || v === 3'h3 || v === 3'h5 || v === 3'h7 || (m == 5 && v === 3'h0);
    endfunction

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        cmp_reg("reg_rdata", e, reg_rdata);
    endtask

    task wait_count(input int i, input logic [15:0] v, input int lim);
        int n;
        n = 0;
        while (timer_count[i] !== v && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        cmp_count("timer_count", v, timer_count[i]);
    endtask

    task reset_dut;
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        sent.delete();
    endtask

    // kind 0 isolated pulses, 1 alternating symbols, 2 muted output
    task check_pulses(input logic [1:0] code, input int kind);
        tx_pkg::level_t lv;
        int last;
        int hits;
        lv = exp_level(code);
        last = -1;
        hits = 0;
        repeat (8) @(negedge clk_sys);
        for (int i = 0; i < 60; i++) begin
            @(negedge clk_sys);
            s[i] = dac_level;
        end
        for (int i = 0; i < 60; i++) begin
            if (kind == 2) cmp_level("muted level", 3'h0, s[i]);
            if (kind == 1) cmp_flag("alternate level", 1'b1, s[i] === lv || s[i] === -lv);
            if (kind == 0 ? s[i] !== 3'h0 : (kind == 1 && i > 0 && s[i] !== s[i - 1])) begin
                if (kind == 0) cmp_level("pulse level", lv, s[i]);
                if (last >= 0) cmp_count("event spacing", 16'(MET_INT + 1), 16'(i - last));
                last = i;
                hits++;
            end
        end
        if (kind != 2) cmp_flag("event count", 1'b1, hits >= 8);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
        if (!rst && cu_valid && cu_ready) sent.push_back({cu_sign, cu_mag});
    end

    always @(negedge clk_sys) begin
        {det_sign, det_mag} <= 2'($random(seed));
        if (data_mode != 0 && dac_level !== 3'h0) begin
            if (sent.size() == 0) begin
                cmp_flag("queued pair", 1'b1, 1'b0);
            end else begin
                pair = sent.pop_front();
                if (data_mode == 2) pair[0] = 1'b0;
                cmp_level("data level", exp_level(pair), dac_level);
            end
        end
    end

    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
        {det_sign, det_mag} = 2'h0;
        active = 1'b1;
        slow = 1'b0;
        tcont = 8'h10;
        for (int i = 0; i < 8; i++) tint[i] = 16'($random(seed)) | 16'h0010;
        tint[4] = 16'(MET_INT);
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        rd(8'h0B, 8'h00);
        rd(8'h0C, 8'h00);
        rd(8'h0D, 8'h00);
        rd(8'h3C, 8'h00);
        wr(8'h0B, 8'hFF);
        rd(8'h0B, 8'h7F);
        wr(8'h0B, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(8'h0C, 8'h01 << k);
            wait_count(k, tint[k], k < 4 ? 1100 : 1);
            if (k < 7) cmp_count("untouched timer", 16'h0000, timer_count[k + 1]);
            rd(8'h0C, 8'h00);
        end
        cmp_count("held timer", tint[0], timer_count[0]);
        tint[1] = tint[1] ^ 16'h0100;
        wr(8'h0C, 8'h02);
        wr(8'h0C, 8'h00);
        repeat (1100) @(negedge clk_sys);
        cmp_count("cancelled reload", tint[1] ^ 16'h0100, timer_count[1]);
        wr(8'h0D, 8'h60);
        wait_count(6, tint[6] - 16'h0005, 7);
        wr(8'h0D, 8'h00);
        @(negedge clk_sys);
        held = timer_count[6];
        repeat (10) @(negedge clk_sys);
        cmp_count("stopped timer", held, timer_count[6]);
        wr(8'h0C, 8'h10);
        wr(8'h0D, 8'h10);
        for (int c = 0; c < 4; c++) begin
            wr(8'h0B, {1'b0, 2'(c), 5'h00});
            check_pulses(2'(c), 0);
            wr(8'h0B, {1'b0, 2'(c), 5'h04});
            check_pulses(2'(c), 1);
        end
        wr(8'h0B, 8'h10);
        check_pulses(2'h0, 2);
        cmp_flag("fifo refuses", 1'b0, cu_ready);
        wr(8'h0B, 8'h12);
        check_pulses(2'h0, 2);
        cmp_flag("muted fifo holds", 1'b0, cu_ready);
        slow = 1'b1;
        for (int d = 1; d < 3; d++) begin
            data_mode = d;
            wr(8'h0B, d == 1 ? 8'h02 : 8'h06);
            active = 1'b1;
            repeat (150) @(negedge clk_sys);
            active = 1'b0;
            repeat (30) @(negedge clk_sys);
            cmp_count("pairs left", 16'h0000, 16'(sent.size()));
            cmp_flag("fifo drained", 1'b1, cu_ready);
        end
        data_mode = 0;
        active = 1'b1;
        for (int m = 1; m < 8; m += 2) begin
            wr(8'h0B, 8'(m));
            repeat (4) @(negedge clk_sys);
            repeat (40) begin
                @(negedge clk_sys);
                cmp_flag("scrambled level", 1'b1, legal(dac_level, m));
            end
        end
        active = 1'b0;
        for (int p = 0; p < 2; p++) begin
            reset_dut();
            wr(8'h0B, p == 1 ? 8'h0F : 8'h07);
            repeat (2) @(negedge clk_sys);
            for (int i = 0; i < 40; i++) begin
                @(negedge clk_sys);
                sig[p][i] = dac_level[2];
            end
        end
        cmp_flag("polynomial choice", 1'b1, sig[0] !== sig[1]);
        complete_run();
    end
endmodule

// ---- hdl/countdown_timer.sv ----
// one reloadable countdown timer
`timescale 1ns/10ps
module countdown_timer #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic tick,
    input wire logic reload_req,
    input wire logic run,
    input wire logic continuous,
    input wire logic [W-1:0] interval,
    // state
    output logic [W-1:0] count,
    output logic reload_taken,
    output logic expire
);
    // a request only acts on a tick, so clearing it first cancels it
    assign reload_taken = tick && reload_req;
    assign expire = tick && !reload_req && run && (count == {{(W-1){1'b0}}, 1'b1});

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (tick) begin
            if (reload_req) begin
                count <= interval;
            end else if (run) begin
                if (count != '0) begin
                    count <= count - 1'b1;
                end else if (continuous) begin
                    count <= interval;
                end
            end
        end
    end
endmodule

// ---- hdl/sym_fifo.sv ----
// symbol fifo with valid/ready on both sides
`timescale 1ns/10ps
module sym_fifo #(
    parameter int W = 2,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // streams
    sym_stream_if.snk wr,
    sym_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = (wptr == rptr);
    assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rptr[AW-1:0]];
    assign push = wr.valid && !full;
    assign pop = rd.ready && !empty;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wptr[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
        end
    end
endmodule

// ---- hdl/tx_symbol_source.sv ----
// transmit symbol source selection and internal timer bank
`timescale 1ns/10ps
`include "tx_defines.svh"

module tx_symbol_source #(
    parameter int TIMER_W = 16,
    parameter int FIFO_DEPTH = 8,
    parameter int SCR_LEN = 23,
    parameter int REMOTE_TAP = 18,
    parameter int LOCAL_TAP = 5
) (
    // clock and reset; one clock edge is one symbol period
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // channel unit transmit interface
    input wire logic cu_valid,
    input wire logic cu_sign,
    input wire logic cu_mag,
    output logic cu_ready,
    // receive detector decisions
    input wire logic det_sign,
    input wire logic det_mag,
    // timer intervals and continuous mode
    input wire logic [7:0][TIMER_W-1:0] timer_interval,
    input wire logic [7:0] timer_continuous,
    // outputs
    output tx_pkg::level_t dac_level,
    output logic [7:0][TIMER_W-1:0] timer_count
);
    localparam int PRE_W = $clog2(`STARTUP_PRESCALE);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(`STARTUP_PRESCALE - 1);

    logic [6:0] tx_modes;
    logic [7:0] timer_reload_request;
    logic [7:0] timer_run_control;
    logic [PRE_W-1:0] prescale;
    logic startup_tick;
    logic [7:0] reload_taken;
    logic [7:0] expire;
    logic meter_expire;
    logic alt_pol;
    logic [SCR_LEN-1:0] scr;
    logic [SCR_LEN-1:0] next_scr;
    tx_pkg::level_t next_level;
    tx_pkg::level_t pulse_level;
    tx_pkg::source_t src;
    logic mute;
    logic remote;
    logic pop;
    logic wr_modes;
    logic wr_reload;
    logic wr_run;
    logic b0;
    logic b1;
    logic [SCR_LEN-1:0] s1;
    logic in_sign;
    logic in_mag;
    logic [10:0] startup_wait;

    sym_stream_if #(.W(2)) cu_if ();
    sym_stream_if #(.W(2)) fifo_if ();

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    function automatic tx_pkg::level_t level_of(input logic sign, input logic mag);
        tx_pkg::level_t lv;
        unique case ({sign, mag})
            2'b00: lv = -3'sd3;
            2'b01: lv = -3'sd1;
            2'b10: lv = 3'sd3;
            2'b11: lv = 3'sd1;
        endcase
        return lv;
    endfunction

    function automatic logic scr_bit(input logic [SCR_LEN-1:0] s, input logic d,
                                     input logic rem);
        return d ^ s[SCR_LEN-1] ^ (rem ? s[REMOTE_TAP-1] : s[LOCAL_TAP-1]);
    endfunction

    // register decode
    assign wr_modes = reg_wr && (reg_addr == `TX_MODES_ADDR);
    assign wr_reload = reg_wr && (reg_addr == `TMR_RELOAD_ADDR);
    assign wr_run = reg_wr && (reg_addr == `TMR_RUN_ADDR);

    // modes are only sampled here, so a change lands between whole symbols
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_modes <= `TX_MODES_RESET;
        end else if (wr_modes) begin
            tx_modes <= reg_wdata[6:0];
        end
    end

    // a write in the cycle of a reload wins, so a fresh request is never lost
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            timer_reload_request <= `TMR_RELOAD_RESET;
        end else if (wr_reload) begin
            timer_reload_request <= reg_wdata;
        end else begin
            timer_reload_request <= timer_reload_request & ~reload_taken;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            timer_run_control <= `TMR_RUN_RESET;
        end else if (wr_run) begin
            timer_run_control <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `TX_MODES_ADDR: reg_rdata <= {1'b0, tx_modes};
                `TMR_RELOAD_ADDR: reg_rdata <= timer_reload_request;
                `TMR_RUN_ADDR: reg_rdata <= timer_run_control;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // prescaler for the startup timers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prescale <= '0;
        end else if (prescale == PRE_LAST) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    assign startup_tick = (prescale == PRE_LAST);

    // bit index equals timer position in the reload and run registers
    for (genvar i = 0; i < 8; i++) begin : g_timer
        countdown_timer #(.W(TIMER_W)) u_timer (
            .clk_sys(clk_sys),
            .rst(rst),
            .tick((i <= `TMR_STARTUP_FOUR) ? startup_tick : 1'b1),
            .reload_req(timer_reload_request[i]),
            .run(timer_run_control[i]),
            .continuous(timer_continuous[i]),
            .interval(timer_interval[i]),
            .count(timer_count[i]),
            .reload_taken(reload_taken[i]),
            .expire(expire[i])
        );
    end

    // pulse modes lean on the meter running continuously
    assign meter_expire = expire[`TMR_METER];

    // channel unit data enters through the fifo
    assign cu_if.valid = cu_valid;
    assign cu_if.data = {cu_sign, cu_mag};
    assign cu_ready = cu_if.ready;

    sym_fifo #(.W(2), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(cu_if),
        .rd(fifo_if)
    );

    assign src = tx_pkg::source_t'(tx_modes[`SRC_MSB:`SRC_LSB]);
    assign mute = tx_modes[`MUTE_BIT];
    assign remote = tx_modes[`POLY_REMOTE_BIT];
    assign pulse_level = level_of(tx_modes[`PULSE_MSB], tx_modes[`PULSE_LSB]);

    // the fifo drains only in data modes, so it backs up to the framer otherwise
    assign pop = !mute && fifo_if.valid && ((src == tx_pkg::SRC_DATA_PLAIN) ||
                 (src == tx_pkg::SRC_DATA_SCRAMBLED) || (src == tx_pkg::SRC_DATA_TWO));
    assign fifo_if.ready = pop;

    always_comb begin
        in_sign = 1'b1;
        in_mag = 1'b1;
        if (src == tx_pkg::SRC_LOOPBACK) begin
            in_sign = det_sign;
            in_mag = det_mag;
        end else if (src == tx_pkg::SRC_DATA_SCRAMBLED) begin
            in_sign = fifo_if.data[1];
            in_mag = fifo_if.data[0];
        end
        b0 = scr_bit(scr, in_sign, remote);
        s1 = {scr[SCR_LEN-2:0], b0};
        b1 = scr_bit(s1, in_mag, remote);
    end

    // underrun in a data mode sends a zero symbol rather than stale data
    always_comb begin
        next_level = 3'sd0;
        next_scr = scr;
        if (!mute) begin
            unique case (src)
                tx_pkg::SRC_ISOLATED: begin
                    next_level = meter_expire ? pulse_level : 3'sd0;
                end
                tx_pkg::SRC_LOOPBACK, tx_pkg::SRC_ONES_FOUR: begin
                    next_level = level_of(b0, b1);
                    next_scr = {s1[SCR_LEN-2:0], b1};
                end
                tx_pkg::SRC_DATA_PLAIN: begin
                    if (fifo_if.valid) begin
                        next_level = level_of(fifo_if.data[1], fifo_if.data[0]);
                    end
                end
                tx_pkg::SRC_ALTERNATE: begin
                    next_level = (alt_pol ^ meter_expire) ? -pulse_level : pulse_level;
                end
                tx_pkg::SRC_DATA_SCRAMBLED: begin
                    if (fifo_if.valid) begin
                        next_level = level_of(b0, b1);
                        next_scr = {s1[SCR_LEN-2:0], b1};
                    end
                end
                tx_pkg::SRC_DATA_TWO: begin
                    if (fifo_if.valid) begin
                        next_level = level_of(fifo_if.data[1], 1'b0);
                    end
                end
                tx_pkg::SRC_ONES_TWO: begin
                    next_level = level_of(b0, 1'b0);
                    next_scr = s1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dac_level <= 3'sd0;
        end else begin
            dac_level <= next_level;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scr <= '0;
        end else begin
            scr <= next_scr;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            alt_pol <= 1'b0;
        end else if (src == tx_pkg::SRC_ALTERNATE && !mute && meter_expire) begin
            alt_pol <= !alt_pol;
        end
    end

    mute_zero_a: assert property (mute |=> dac_level == 3'sd0)
        else $error("muted transmitter produced a nonzero symbol");

    iso_gap_a: assert property (!mute && src == tx_pkg::SRC_ISOLATED && !meter_expire
        |=> dac_level == 3'sd0)
        else $error("isolated pulse mode sent a symbol between meter expiries");

    iso_level_a: assert property (!mute && src == tx_pkg::SRC_ISOLATED && meter_expire
        |=> dac_level == $past(pulse_level))
        else $error("isolated pulse level does not match pulse level field");

    alt_hold_a: assert property (!mute && src == tx_pkg::SRC_ALTERNATE && !meter_expire
        && $past(!mute && src == tx_pkg::SRC_ALTERNATE && !wr_modes) && !wr_modes
        |=> $stable(dac_level))
        else $error("alternating output changed without a meter expiry");

    plain_data_a: assert property (!mute && src == tx_pkg::SRC_DATA_PLAIN && fifo_if.valid
        |=> dac_level == level_of($past(fifo_if.data[1]), $past(fifo_if.data[0])))
        else $error("unscrambled data symbol does not match fifo head");

    two_level_a: assert property (!mute && src == tx_pkg::SRC_ONES_TWO
        |=> dac_level == 3'sd3 || dac_level == -3'sd3)
        else $error("two-level scrambled ones produced an inner level");

    two_data_a: assert property (!mute && src == tx_pkg::SRC_DATA_TWO && fifo_if.valid
        |=> dac_level == ($past(fifo_if.data[1]) ? 3'sd3 : -3'sd3))
        else $error("two-level data symbol wrong");

    pop_mode_a: assert property (!cu_ready && (mute || !(src == tx_pkg::SRC_DATA_PLAIN
        || src == tx_pkg::SRC_DATA_SCRAMBLED || src == tx_pkg::SRC_DATA_TWO)) |=> !cu_ready)
        else $error("fifo drained outside a data mode");

    meter_reload_a: assert property (timer_reload_request[`TMR_METER] && !wr_reload
        |=> !timer_reload_request[`TMR_METER]
        && timer_count[`TMR_METER] == $past(timer_interval[`TMR_METER]))
        else $error("meter reload not done within one symbol");

    // a pending startup reload may wait one whole prescale period, too long for a delay range
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            startup_wait <= 11'h000;
        end else if (wr_reload || !timer_reload_request[`TMR_STARTUP_ONE]) begin
            startup_wait <= 11'h000;
        end else begin
            startup_wait <= startup_wait + 11'h001;
        end
    end

    startup_reload_a: assert property (startup_wait <= 11'h400)
        else $error("startup reload not done within 1024 symbols");

    self_clear_a: assert property (|reload_taken && !wr_reload
        |=> (timer_reload_request & $past(reload_taken)) == 8'h00)
        else $error("reload bit stayed set after reload");

    run_hold_a: assert property (!timer_run_control[`TMR_GENERAL_A] && !wr_reload
        && !timer_reload_request[`TMR_GENERAL_A] |=> $stable(timer_count[`TMR_GENERAL_A]))
        else $error("stopped timer changed its count");

    run_count_a: assert property (timer_run_control[`TMR_QUALITY]
        && !timer_reload_request[`TMR_QUALITY] && timer_count[`TMR_QUALITY] != '0
        |=> timer_count[`TMR_QUALITY] == $past(timer_count[`TMR_QUALITY]) - 1'b1)
        else $error("running timer did not decrement by one");
endmodule

// ---- inc/sym_stream_if.sv ----
// valid/ready symbol stream between the block's own modules
`timescale 1ns/10ps
interface sym_stream_if #(parameter int W = 2);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- inc/tx_defines.svh ----
// register offsets, field positions, reset values and timing counts of the transmit source block
`ifndef TX_DEFINES_SVH
`define TX_DEFINES_SVH

`define TX_MODES_ADDR 8'h0B
`define TMR_RELOAD_ADDR 8'h0C
`define TMR_RUN_ADDR 8'h0D

`define TX_MODES_RESET 7'h00
`define TMR_RELOAD_RESET 8'h00
`define TMR_RUN_RESET 8'h00

// transmitter modes fields
`define SRC_LSB 0
`define SRC_MSB 2
`define POLY_REMOTE_BIT 3
`define MUTE_BIT 4
`define PULSE_LSB 5
`define PULSE_MSB 6

// timer bit positions in the reload and run registers
`define TMR_STARTUP_ONE 0
`define TMR_STARTUP_TWO 1
`define TMR_STARTUP_THREE 2
`define TMR_STARTUP_FOUR 3
`define TMR_METER 4
`define TMR_QUALITY 5
`define TMR_GENERAL_A 6
`define TMR_GENERAL_B 7

// startup timers advance once per this many symbols
`define STARTUP_PRESCALE 1024

`endif

// ---- inc/tx_pkg.sv ----
// types shared by the transmit source block
package tx_pkg;
    typedef enum logic [2:0] {
        SRC_ISOLATED,
        SRC_LOOPBACK,
        SRC_DATA_PLAIN,
        SRC_ONES_FOUR,
        SRC_ALTERNATE,
        SRC_DATA_SCRAMBLED,
        SRC_DATA_TWO,
        SRC_ONES_TWO
    } source_t;

    typedef logic signed [2:0] level_t;
endpackage
